// File: rtl/aof_pkg.sv
package aof_pkg;

    // ----------------------------------------
    // widths and depths
    // ----------------------------------------
    localparam int SAMPLE_W = 14;
    localparam int CHANNELS = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 2 * SAMPLE_W;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SEL_W = 4;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_PAT_EN = 8'h06;
    localparam logic [7:0] ADDR_OVR_LSB = 8'h07;
    localparam logic [7:0] ADDR_ALIGN_CODING = 8'h09;
    localparam logic [7:0] ADDR_SEL_A = 8'h0a;
    localparam logic [7:0] ADDR_SEL_B = 8'h0b;
    localparam logic [7:0] ADDR_CUSTOM_HI = 8'h0e;
    localparam logic [7:0] ADDR_CUSTOM_LO = 8'h0f;
    localparam logic [7:0] ADDR_STATUS = 8'h30;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int SOFT_RESET_BIT = 0;
    localparam int PAT_EN_BIT = 1;
    localparam int OVR_LSB_BIT = 0;
    localparam int CODING_BIT = 0;
    localparam int ALIGN_BIT = 1;
    localparam int SEL_A_LSB = 0;
    localparam int SEL_B_LSB = 4;
    localparam int CUSTOM_HI_LSB = 6;
    localparam int CUSTOM_LO_LSB = 2;
    localparam int STAT_DROP_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_EMPTY_BIT = 2;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic RST_CTRL = 1'b0;
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam logic [13:0] RST_CUSTOM = 14'h0000;

    // ----------------------------------------
    // pattern selector codes
    // ----------------------------------------
    localparam logic [3:0] PAT_NORMAL = 4'h0;
    localparam logic [3:0] PAT_ZEROS = 4'h1;
    localparam logic [3:0] PAT_ONES = 4'h2;
    localparam logic [3:0] PAT_TOGGLE = 4'h3;
    localparam logic [3:0] PAT_RAMP = 4'h4;
    localparam logic [3:0] PAT_CUSTOM = 4'h5;
    localparam logic [3:0] PAT_DESKEW = 4'h6;
    localparam logic [3:0] PAT_PRBS = 4'h8;
    localparam logic [3:0] PAT_SINE = 4'h9;

    // ----------------------------------------
    // fixed words
    // ----------------------------------------
    localparam logic [13:0] WORD_ZEROS = 14'h0000;
    localparam logic [13:0] WORD_ONES = 14'h3fff;
    localparam logic [13:0] WORD_TOGGLE = 14'h2aaa;
    localparam logic [13:0] WORD_DESKEW = 14'h2aaa;
    localparam logic [13:0] WORD_MSB = 14'h2000;
    localparam logic [13:0] RAMP_START = 14'h0000;
    localparam logic [13:0] RAMP_STEP = 14'h0001;

    // ----------------------------------------
    // pseudo-random generator: x^15 + x^14 + 1
    // ----------------------------------------
    localparam int PRBS_W = 15;
    localparam int PRBS_TAP_A = 14;
    localparam int PRBS_TAP_B = 13;
    localparam logic [14:0] PRBS_SEED = 15'h0001;

    // ----------------------------------------
    // sine table
    // ----------------------------------------
    localparam int SINE_IDX_W = 3;
    localparam logic [2:0] SINE_STEP = 3'h1;
    localparam logic [13:0] SINE_P0 = 14'h0000;
    localparam logic [13:0] SINE_P1 = 14'h095f;
    localparam logic [13:0] SINE_P2 = 14'h2000;
    localparam logic [13:0] SINE_P3 = 14'h36a0;
    localparam logic [13:0] SINE_P4 = 14'h3fff;

endpackage : aof_pkg

// File: rtl/aof_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module aof_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    logic push;
    logic pop;

    // ----------------------------------------
    // flags
    // ----------------------------------------
    // honest flags straight from the count
    assign in_ready = (count != CNT_FULL);
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // ----------------------------------------
    // storage
    // ----------------------------------------
    // no reset on the array, contents only matter below the count
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at depth, so depth need not be a power of two
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

endmodule : aof_fifo

`default_nettype wire

// File: rtl/aof_sine_rom.sv
`timescale 1ns/1ns
`default_nettype none

module aof_sine_rom
    import aof_pkg::*;
(
    input wire logic clk,
    input wire logic [SINE_IDX_W-1:0] addr,
    output logic [SAMPLE_W-1:0] data
);

    // ----------------------------------------
    // registered table read
    // ----------------------------------------
    // second half mirrors the first, only five distinct points are stored
    always_ff @(posedge clk) begin
        case (addr)
            3'h0: data <= SINE_P0;
            3'h1: data <= SINE_P1;
            3'h2: data <= SINE_P2;
            3'h3: data <= SINE_P3;
            3'h4: data <= SINE_P4;
            3'h5: data <= SINE_P3;
            3'h6: data <= SINE_P2;
            3'h7: data <= SINE_P1;
            default: data <= SINE_P0;
        endcase
    end

endmodule : aof_sine_rom

`default_nettype wire

// File: rtl/aof_top.sv
`timescale 1ns/1ns
`default_nettype none

module aof_top
    import aof_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] sample_a,
    input wire logic [SAMPLE_W-1:0] sample_b,
    input wire logic overrange_flag_a,
    input wire logic overrange_flag_b,
    output logic out_valid,
    input wire logic out_ready,
    output logic [SAMPLE_W-1:0] out_word_a,
    output logic [SAMPLE_W-1:0] out_word_b
);

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic pat_en;
    logic overrange_in_lsb;
    logic align_pat;
    logic coding_offset;
    logic [SEL_W-1:0] chan_a_pattern_sel;
    logic [SEL_W-1:0] chan_b_pattern_sel;
    logic [SAMPLE_W-1:0] custom_word;
    logic drop_flag;
    logic soft_reset;
    logic cfg_reset;
    logic wr_sel_a;
    logic wr_sel_b;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    logic accept;
    logic stage_free;
    logic st_valid;
    logic [FIFO_W-1:0] st_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FIFO_W-1:0] fifo_out_data;
    logic [SAMPLE_W-1:0] word [CHANNELS];
    logic [SAMPLE_W-1:0] raw [CHANNELS];
    logic overrange_flag [CHANNELS];
    logic [SEL_W-1:0] sel [CHANNELS];
    logic restart [CHANNELS];

    // ----------------------------------------
    // generator state, one set per channel
    // ----------------------------------------
    logic [SAMPLE_W-1:0] ramp [CHANNELS];
    logic [SAMPLE_W-1:0] next_ramp [CHANNELS];
    logic tog [CHANNELS];
    logic next_tog [CHANNELS];
    logic [PRBS_W-1:0] prbs [CHANNELS];
    logic [PRBS_W-1:0] next_prbs [CHANNELS];
    logic [SINE_IDX_W-1:0] sidx [CHANNELS];
    logic [SINE_IDX_W-1:0] next_sidx [CHANNELS];
    logic [SAMPLE_W-1:0] sine [CHANNELS];

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // converter core delivers offset binary; twos complement flips the msb
    function automatic logic [SAMPLE_W-1:0] fmt_sample(
        input logic [SAMPLE_W-1:0] s,
        input logic ov,
        input logic offset_bin,
        input logic ovr_lsb
    );
        logic [SAMPLE_W-1:0] r;
        r = offset_bin ? s : (s ^ WORD_MSB);
        if (ovr_lsb) begin
            r[0] = ov;
        end
        return r;
    endfunction : fmt_sample

    // selector decode, used for both channels
    function automatic logic [SAMPLE_W-1:0] pick_word(
        input logic en,
        input logic [SEL_W-1:0] code,
        input logic [SAMPLE_W-1:0] normal,
        input logic [SAMPLE_W-1:0] rmp,
        input logic tg,
        input logic [PRBS_W-1:0] rnd,
        input logic [SAMPLE_W-1:0] sn,
        input logic [SAMPLE_W-1:0] cust
    );
        logic [SAMPLE_W-1:0] r;
        r = normal;
        if (en) begin
            case (code)
                PAT_NORMAL: r = normal;
                PAT_ZEROS: r = WORD_ZEROS;
                PAT_ONES: r = WORD_ONES;
                PAT_TOGGLE: r = tg ? ~WORD_TOGGLE : WORD_TOGGLE;
                PAT_RAMP: r = rmp;
                PAT_CUSTOM: r = cust;
                PAT_DESKEW: r = WORD_DESKEW;
                PAT_PRBS: r = rnd[SAMPLE_W-1:0];
                PAT_SINE: r = sn;
                // undefined codes are a software fault; zeros keep the line quiet
                default: r = WORD_ZEROS;
            endcase
        end
        return r;
    endfunction : pick_word

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    assign soft_reset = reg_wr && (reg_addr == ADDR_PAT_EN) && reg_wdata[SOFT_RESET_BIT];
    assign cfg_reset = reset || soft_reset;
    assign wr_sel_a = reg_wr && (reg_addr == ADDR_SEL_A);
    assign wr_sel_b = reg_wr && (reg_addr == ADDR_SEL_B);

    // soft reset self-clears: it is only the write pulse, never stored
    always_ff @(posedge clk) begin
        if (cfg_reset) begin
            pat_en <= RST_CTRL;
            overrange_in_lsb <= RST_CTRL;
            align_pat <= RST_CTRL;
            coding_offset <= RST_CTRL;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_PAT_EN: pat_en <= reg_wdata[PAT_EN_BIT];
                ADDR_OVR_LSB: overrange_in_lsb <= reg_wdata[OVR_LSB_BIT];
                ADDR_ALIGN_CODING: begin
                    align_pat <= reg_wdata[ALIGN_BIT];
                    coding_offset <= reg_wdata[CODING_BIT];
                end
                default: ;
            endcase
        end
    end

    // pattern selectors
    always_ff @(posedge clk) begin
        if (cfg_reset) begin
            chan_a_pattern_sel <= RST_SEL;
            chan_b_pattern_sel <= RST_SEL;
        end else begin
            if (wr_sel_a) begin
                chan_a_pattern_sel <= reg_wdata[SEL_A_LSB +: SEL_W];
            end
            if (wr_sel_b) begin
                chan_b_pattern_sel <= reg_wdata[SEL_B_LSB +: SEL_W];
            end
        end
    end

    // custom word split across two registers
    always_ff @(posedge clk) begin
        if (cfg_reset) begin
            custom_word <= RST_CUSTOM;
        end else if (reg_wr && reg_addr == ADDR_CUSTOM_HI) begin
            custom_word[SAMPLE_W-1:CUSTOM_HI_LSB] <= reg_wdata;
        end else if (reg_wr && reg_addr == ADDR_CUSTOM_LO) begin
            custom_word[CUSTOM_HI_LSB-1:0] <= reg_wdata[DATA_W-1:CUSTOM_LO_LSB];
        end
    end

    // sticky drop flag, write one to clear; a new drop wins over the clear
    always_ff @(posedge clk) begin
        if (cfg_reset) begin
            drop_flag <= RST_CTRL;
        end else if (sample_valid && !stage_free) begin
            drop_flag <= 1'b1;
        end else if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STAT_DROP_BIT]) begin
            drop_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    // data stand for one cycle only; write-only and reserved bits read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            case (reg_addr)
                ADDR_PAT_EN: reg_rdata[PAT_EN_BIT] <= pat_en;
                ADDR_OVR_LSB: reg_rdata[OVR_LSB_BIT] <= overrange_in_lsb;
                ADDR_ALIGN_CODING: begin
                    reg_rdata[ALIGN_BIT] <= align_pat;
                    reg_rdata[CODING_BIT] <= coding_offset;
                end
                ADDR_SEL_A: reg_rdata[SEL_A_LSB +: SEL_W] <= chan_a_pattern_sel;
                ADDR_SEL_B: reg_rdata[SEL_B_LSB +: SEL_W] <= chan_b_pattern_sel;
                ADDR_CUSTOM_HI: reg_rdata <= custom_word[SAMPLE_W-1:CUSTOM_HI_LSB];
                ADDR_CUSTOM_LO: begin
                    reg_rdata[DATA_W-1:CUSTOM_LO_LSB] <= custom_word[CUSTOM_HI_LSB-1:0];
                end
                ADDR_STATUS: begin
                    reg_rdata[STAT_DROP_BIT] <= drop_flag;
                    reg_rdata[STAT_FULL_BIT] <= !fifo_in_ready;
                    reg_rdata[STAT_EMPTY_BIT] <= !fifo_out_valid;
                end
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ----------------------------------------
    // per-channel inputs
    // ----------------------------------------
    assign raw[0] = sample_a;
    assign raw[1] = sample_b;
    assign overrange_flag[0] = overrange_flag_a;
    assign overrange_flag[1] = overrange_flag_b;
    assign sel[0] = chan_a_pattern_sel;
    assign sel[1] = chan_b_pattern_sel;
    // choosing a new pattern restarts that channel's generators from phase zero, except channel b while aligned, which copies channel a
    assign restart[0] = wr_sel_a;
    assign restart[1] = wr_sel_b;

    // ----------------------------------------
    // stall logic
    // ----------------------------------------
    // generators step only on accepted samples or restart on a select write, so a full fifo behind a held stage freezes their steps
    assign stage_free = !st_valid || fifo_in_ready;
    assign accept = sample_valid && stage_free;

    // ----------------------------------------
    // pattern generators
    // ----------------------------------------
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            logic [SAMPLE_W-1:0] own_ramp;
            logic own_tog;
            logic [PRBS_W-1:0] own_prbs;
            logic [SINE_IDX_W-1:0] own_sidx;

            // free-running step of this channel alone
            always_comb begin
                own_ramp = ramp[c] + RAMP_STEP;
                own_tog = !tog[c];
                own_prbs = {prbs[c][PRBS_W-2:0],
                            prbs[c][PRBS_TAP_A] ^ prbs[c][PRBS_TAP_B]};
                own_sidx = sidx[c] + SINE_STEP;
                if (restart[c]) begin
                    own_ramp = RAMP_START;
                    own_tog = 1'b0;
                    own_prbs = PRBS_SEED;
                    own_sidx = '0;
                end
            end

            // channel b copies channel a's next state while aligned
            always_comb begin
                if (c != 0 && align_pat) begin
                    next_ramp[c] = next_ramp[0];
                    next_tog[c] = next_tog[0];
                    next_prbs[c] = next_prbs[0];
                    next_sidx[c] = next_sidx[0];
                end else if (accept || restart[c]) begin
                    next_ramp[c] = own_ramp;
                    next_tog[c] = own_tog;
                    next_prbs[c] = own_prbs;
                    next_sidx[c] = own_sidx;
                end else begin
                    next_ramp[c] = ramp[c];
                    next_tog[c] = tog[c];
                    next_prbs[c] = prbs[c];
                    next_sidx[c] = sidx[c];
                end
            end

            // generator state registers
            always_ff @(posedge clk) begin
                if (reset) begin
                    ramp[c] <= RAMP_START;
                    tog[c] <= 1'b0;
                    prbs[c] <= PRBS_SEED;
                    sidx[c] <= '0;
                end else begin
                    ramp[c] <= next_ramp[c];
                    tog[c] <= next_tog[c];
                    prbs[c] <= next_prbs[c];
                    sidx[c] <= next_sidx[c];
                end
            end

            // table read tracks the index register, so data match sidx
            aof_sine_rom u_sine (
                .clk(clk),
                .addr(next_sidx[c]),
                .data(sine[c])
            );

            // word for the current generator phase
            assign word[c] = pick_word(pat_en, sel[c],
                                       fmt_sample(raw[c], overrange_flag[c], coding_offset,
                                                  overrange_in_lsb),
                                       ramp[c], tog[c], prbs[c], sine[c], custom_word);
        end
    endgenerate

    // ----------------------------------------
    // stage into the fifo
    // ----------------------------------------
    // one stage register between the selector and the fifo
    always_ff @(posedge clk) begin
        if (reset) begin
            st_valid <= 1'b0;
            st_data <= '0;
        end else if (accept) begin
            st_valid <= 1'b1;
            st_data <= {word[0], word[1]};
        end else if (fifo_in_ready) begin
            st_valid <= 1'b0;
        end
    end

    aof_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(st_valid),
        .in_ready(fifo_in_ready),
        .in_data(st_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------
    // output register
    // ----------------------------------------
    // outputs come from flops; the fifo drains only when this slot frees
    assign fifo_out_ready = !out_valid || out_ready;

    always_ff @(posedge clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_word_a <= '0;
            out_word_b <= '0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            out_valid <= 1'b1;
            out_word_a <= fifo_out_data[FIFO_W-1:SAMPLE_W];
            out_word_b <= fifo_out_data[SAMPLE_W-1:0];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule : aof_top

`default_nettype wire

// File: bench/aof_sink.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// downstream ready pacing
// ----
module aof_sink (
    input wire logic clk,
    input wire logic stall,
    input wire logic slow,
    output logic out_ready
);
    // registered ready, so it never reacts to a word in its own cycle
    always_ff @(posedge clk) begin
        out_ready <= !stall && !(slow && out_ready); // slow: every other cycle
    end
endmodule : aof_sink
`default_nettype wire

// File: bench/aof_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// port checks
// ----
module aof_chk
    import aof_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [SAMPLE_W-1:0] out_word_a,
    input wire logic [SAMPLE_W-1:0] out_word_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // read data stands one cycle, zero otherwise
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
    // unused bits of the select, overrange and align/coding registers read zero
    chk_sela_upper: assert property (
        reg_rd && reg_addr == ADDR_SEL_A |=> reg_rdata[7:4] == 4'h0) else $error("sel a bits");
    chk_selb_lower: assert property (
        reg_rd && reg_addr == ADDR_SEL_B |=> reg_rdata[3:0] == 4'h0) else $error("sel b bits");
    chk_ovr_upper: assert property (
        reg_rd && reg_addr == ADDR_OVR_LSB |=> reg_rdata[7:1] == 7'h00) else $error("ovr bits");
    chk_coding_upper: assert property (
        reg_rd && reg_addr == ADDR_ALIGN_CODING |=> reg_rdata[7:2] == 6'h00)
        else $error("coding bits");
    // a stalled word pair must not vanish or change
    chk_hold_valid: assert property (
        out_valid && !out_ready |=> out_valid) else $error("valid dropped");
    chk_hold_words: assert property (
        out_valid && !out_ready |=> $stable(out_word_a) && $stable(out_word_b))
        else $error("words changed");
    // empty path: a taken sample shows up within the pipeline depth
    chk_word_latency: assert property (
        sample_valid && !out_valid ##1 !out_valid |-> ##[1:2] out_valid)
        else $error("word late");
endmodule : aof_chk
bind aof_top aof_chk u_chk (.clk, .reset, .reg_addr, .reg_rd, .reg_rdata, .sample_valid,
    .out_valid, .out_ready, .out_word_a, .out_word_b);
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import aof_pkg::*;
;
    logic clk, reset, reg_wr, reg_rd, sample_valid, overrange_flag_a, overrange_flag_b;
    logic out_valid, out_ready, stall, slow, pe, cod, ovl, al;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [13:0] sample_a, sample_b, out_word_a, out_word_b, cust, ka, kb, qa[$], qb[$];
    logic [14:0] la, lb;
    logic [3:0] ca, cb;
    logic [13:0] sine[8] = '{14'h0, 14'h95f, 14'h2000, 14'h36a0, 14'h3fff, 14'h36a0, 14'h2000, 14'h95f};
    logic [3:0] cs[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
    int err_total = 0;
    int check_count = 0;
    aof_top dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid,
        .sample_a, .sample_b, .overrange_flag_a, .overrange_flag_b, .out_valid, .out_ready,
        .out_word_a, .out_word_b);
    aof_sink sink (.clk, .stall, .slow, .out_ready);
    // ----
    // clock and helpers
    // ----
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic final_report();
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic fail(input string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail
    // write, then mirror the field; a select write restarts its generators
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        case (a)
            ADDR_PAT_EN: pe = d[1];
            ADDR_OVR_LSB: ovl = d[0];
            ADDR_ALIGN_CODING: {al, cod} = d[1:0];
            ADDR_SEL_A: {ca, ka, la} = {d[3:0], 14'h0, 15'h1};
            ADDR_SEL_B: {cb, kb, lb} = {d[7:4], 14'h0, 15'h1};
            ADDR_CUSTOM_HI: cust[13:6] = d;
            ADDR_CUSTOM_LO: cust[5:0] = d[7:2];
            default: ;
        endcase
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check_count++;
        if (reg_rdata !== e) fail("read");
    endtask : rd
    function automatic logic [13:0] gen(input logic [3:0] c, input logic [13:0] k,
        input logic [14:0] l, input logic [13:0] s, input logic ov);
        logic [13:0] n;
        n = cod ? s : {~s[13], s[12:0]};
        if (ovl) n[0] = ov;
        if (!pe) return n;
        case (c)
            4'h0: return n;
            4'h1: return 14'h0;
            4'h2: return 14'h3fff;
            4'h3: return k[0] ? 14'h1555 : 14'h2aaa;
            4'h4: return k;
            4'h5: return cust;
            4'h6: return 14'h2aaa;
            4'h8: return l[13:0];
            4'h9: return sine[k[2:0]];
            default: return 14'h0;
        endcase
    endfunction : gen
    // back-to-back samples; only the first keep of them expect a word
    task automatic send(input int n, input int keep);
        logic [13:0] va;
        logic [13:0] vb;
        for (int i = 0; i < n; i++) begin
            va = 14'(i * 37 + 5);
            vb = 14'h3fff - 14'(i);
            @(posedge clk);
            sample_valid <= 1'b1;
            sample_a <= va;
            sample_b <= vb;
            overrange_flag_a <= i[0];
            overrange_flag_b <= !i[0];
            if (al) {kb, lb} = {ka, la};
            if (i < keep) qa.push_back(gen(ca, ka, la, va, i[0]));
            if (i < keep) qb.push_back(gen(cb, kb, lb, vb, !i[0]));
            // word shows the current state, the shifter steps after it
            la = {la[13:0], la[14] ^ la[13]};
            lb = {lb[13:0], lb[14] ^ lb[13]};
            ka++;
            kb++;
        end
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask : send
    task automatic drain();
        for (int i = 0; i < 400 && qa.size() > 0; i++) @(posedge clk);
        if (qa.size() > 0) fail("drain timeout");
        if (qa.size() > 0) final_report();
    endtask : drain
    // every accepted pair is compared in order
    always @(posedge clk) begin
        if (!reset && out_valid === 1'b1 && out_ready === 1'b1) begin
            check_count++;
            if (qa.size() == 0) fail("extra word");
            else if (out_word_a !== qa[0] || out_word_b !== qb[0]) fail("word");
            if (qa.size() > 0) void'(qa.pop_front());
            if (qb.size() > 0) void'(qb.pop_front());
        end
    end
    // ----
    // main sequence
    // ----
    initial begin
        {reset, reg_wr, reg_rd, sample_valid, overrange_flag_a, overrange_flag_b} = 6'h20;
        {stall, slow, reg_addr, reg_wdata, sample_a, sample_b} = '0;
        {pe, cod, ovl, al, ca, cb, cust, ka, kb, la, lb} = {54'h0, 15'h1, 15'h1};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_SEL_B, 8'h00);
        rd(8'h20, 8'h00);
        wr(ADDR_SEL_A, 8'hf9);
        rd(ADDR_SEL_A, 8'h09);
        wr(ADDR_SEL_B, 8'h9f);
        rd(ADDR_SEL_B, 8'h90);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_OVR_LSB, {7'h0, m[0]});
            wr(ADDR_ALIGN_CODING, {7'h0, m[1]});
            send(4, 4);
            drain();
        end
        wr(ADDR_CUSTOM_HI, 8'ha5);
        wr(ADDR_CUSTOM_LO, 8'h3c);
        wr(ADDR_PAT_EN, 8'h02);
        rd(ADDR_PAT_EN, 8'h02);
        slow <= 1'b1;
        foreach (cs[i]) begin
            wr(ADDR_SEL_A, {4'h0, cs[i]});
            wr(ADDR_SEL_B, {cs[8 - i], 4'h0});
            send(10, 10);
            drain();
        end
        slow <= 1'b0;
        wr(ADDR_SEL_B, 8'h40);
        wr(ADDR_SEL_A, 8'h04);
        send(16386, 16386);
        drain();
        wr(ADDR_ALIGN_CODING, 8'h02);
        wr(ADDR_SEL_A, 8'h04);
        send(3, 3);
        drain();
        wr(ADDR_ALIGN_CODING, 8'h00);
        wr(ADDR_SEL_A, 8'h04);
        send(2, 2);
        drain();
        wr(ADDR_PAT_EN, 8'h00);
        stall <= 1'b1;
        send(11, 10);
        rd(ADDR_STATUS, 8'h03);
        stall <= 1'b0;
        drain();
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, 8'h04);
        wr(ADDR_PAT_EN, 8'h01);
        rd(ADDR_SEL_B, 8'h00);
        final_report();
    end
endmodule : testbench
`default_nettype wire
